/* File: hdl/tps_timer0.sv */
// timer0 with shared prescaler, source select and mode register
//
// Functional notes
// R1 - timer prescale ratio 2 to 256
// R2 - watchdog reset mode ratio 1 to 128
// R3 - watchdog interrupt mode ratio 2 to 256
// R4 - assignment bit one routes prescaler to watchdog
// R5 - software sets prescaler before enabling events
// R6 - edge bit one counts falling pin edges
// R7 - edge bit also applies to low oscillator
// R8 - source bits pick instr, pin, low oscillator
// R9 - bit six is plain storage only
// R10 - mode register via dedicated instructions only
// R11 - count view reads prescaler, resets ones
// R12 - timer counts only while enabled
// R13 - overflow sets flag, software clears it
// R14 - eight bit up counter wraps, flags once
// R15 - watchdog owns prescaler: timer undivided
module tps_timer0
  import tps_pkg::*;
(
  input  wire logic       core_clk_i,        // instruction clock
  input  wire logic       reset_i,           // async reset, active high
  input  wire logic       mode_wr_i,         // mode write instruction strobe
  input  wire logic [7:0] mode_wdata_i,      // mode write data
  input  wire logic       mode_rd_i,         // mode read instruction strobe
  output logic      [7:0] mode_rdata_o,      // mode read data
  input  wire logic       sfr_rd_i,          // f-page register read strobe
  input  wire logic [7:0] sfr_addr_i,        // f-page register address
  output logic      [7:0] sfr_rdata_o,       // f-page read data
  output logic            sfr_rvalid_o,      // f-page read data valid
  input  wire logic       ext_clk_pin_i,     // external count clock pin
  input  wire logic       low_osc_i,         // low-frequency oscillator
  input  wire logic       run_enable_i,      // timer0 run enable
  input  wire logic       wdt_int_mode_i,    // watchdog timeout interrupts
  input  wire logic       wdt_tick_i,        // watchdog base period tick
  input  wire logic       flag_clr_i,        // overflow flag clear strobe
  output logic      [7:0] timer_count_o,     // timer0 count
  output logic            overflow_flag_o,   // timer0 overflow flag
  output logic            wdt_timeout_o      // prescaled watchdog timeout
);

  //////////////////////////////////////////////////////////////////////////
  // state

  tps_mode_t  mode;
  tps_mode_t  next_mode;
  logic [7:0] psc_cnt;
  logic [7:0] next_psc_cnt;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic       flag;
  logic       next_flag;
  logic       wdt_to;
  logic       next_wdt_to;
  logic       pin_prev;
  logic       losc_prev;
  logic [7:0] mode_rdata;
  logic [7:0] next_mode_rdata;
  logic [7:0] sfr_rdata;
  logic [7:0] next_sfr_rdata;
  logic       sfr_rvalid;

  tps_src_t   src;
  logic       src_level;
  logic       src_prev;
  logic       src_evt;
  logic [3:0] div_exp;
  logic [7:0] div_mask;
  logic       psc_in;
  logic       psc_tick;
  logic       timer_inc;
  logic       flag_set;

  //////////////////////////////////////////////////////////////////////////
  // count source and edge select

  always_comb begin
    if (!mode.count_source_select) begin
      src = TPS_SRC_INSTR;                                   // R8
    end else if (mode.low_osc_source_select) begin
      src = TPS_SRC_LOSC;                                    // R8
    end else begin
      src = TPS_SRC_PIN;                                     // R8
    end
  end

  always_comb begin
    src_level = ext_clk_pin_i;
    src_prev  = pin_prev;
    src_evt   = 1'b1;
    case (src)
      TPS_SRC_INSTR: begin
        src_evt = 1'b1;
      end
      TPS_SRC_PIN, TPS_SRC_LOSC: begin
        if (src == TPS_SRC_LOSC) begin
          src_level = low_osc_i;
          src_prev  = losc_prev;
        end
        // falling edge when edge bit set, else rising
        if (mode.count_edge_select) begin
          src_evt = src_prev & ~src_level;                   // R6 R7
        end else begin
          src_evt = ~src_prev & src_level;                   // R6 R7
        end
      end
      default: begin
        src_evt = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // shared prescaler

  always_comb begin
    if (!mode.prescale_to_watchdog) begin
      div_exp = {1'b0, mode.prescale_ratio_select} + TPS_EXP_ONE;  // R1
    end else if (wdt_int_mode_i) begin
      div_exp = {1'b0, mode.prescale_ratio_select} + TPS_EXP_ONE;  // R3
    end else begin
      div_exp = {1'b0, mode.prescale_ratio_select};                // R2
    end
  end

  // low bits that must roll to zero before a tick passes
  for (genvar i = 0; i < TPS_PSC_BITS; i++) begin : g_mask
    assign div_mask[i] = (4'(i) < div_exp);
  end

  always_comb begin
    psc_in       = mode.prescale_to_watchdog ? wdt_tick_i              // R4
                                             : (src_evt & run_enable_i);
    next_psc_cnt = psc_in ? psc_cnt + TPS_ONE8 : psc_cnt;
    psc_tick     = psc_in && ((next_psc_cnt & div_mask) == TPS_ZERO8);
  end

  //////////////////////////////////////////////////////////////////////////
  // timer0, overflow flag and watchdog timeout

  always_comb begin
    if (mode.prescale_to_watchdog) begin
      timer_inc = src_evt & run_enable_i;                    // R15 R12
    end else begin
      timer_inc = psc_tick;                                  // R4 R12
    end
    next_timer  = timer_inc ? timer + TPS_ONE8 : timer;      // R14
    flag_set    = timer_inc && (timer == TPS_TMR_MAX);       // R14
    next_flag   = flag_set | (flag & ~flag_clr_i);           // R13
    next_wdt_to = mode.prescale_to_watchdog & psc_tick;      // R4
  end

  //////////////////////////////////////////////////////////////////////////
  // mode register and read ports

  always_comb begin
    next_mode       = mode;
    next_mode_rdata = mode_rdata;
    next_sfr_rdata  = sfr_rdata;
    if (mode_wr_i) begin
      next_mode = tps_mode_t'(mode_wdata_i);                 // R10 R9
    end
    if (mode_rd_i) begin
      next_mode_rdata = mode;                                // R10 R9
    end
    if (sfr_rd_i) begin
      if (sfr_addr_i == TPS_PSCV_ADDR) begin
        next_sfr_rdata = psc_cnt;                            // R11
      end else begin
        next_sfr_rdata = TPS_ZERO8;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode       <= tps_mode_t'(TPS_MODE_RESET);
      psc_cnt    <= TPS_PSC_RESET;                           // R11
      timer      <= TPS_TMR_RESET;
      flag       <= 1'b0;
      wdt_to     <= 1'b0;
      pin_prev   <= 1'b0;
      losc_prev  <= 1'b0;
      mode_rdata <= TPS_ZERO8;
      sfr_rdata  <= TPS_ZERO8;
      sfr_rvalid <= 1'b0;
    end else begin
      mode       <= next_mode;
      psc_cnt    <= next_psc_cnt;
      timer      <= next_timer;
      flag       <= next_flag;
      wdt_to     <= next_wdt_to;
      pin_prev   <= ext_clk_pin_i;
      losc_prev  <= low_osc_i;
      mode_rdata <= next_mode_rdata;
      sfr_rdata  <= next_sfr_rdata;
      sfr_rvalid <= sfr_rd_i;
    end
  end

  assign mode_rdata_o    = mode_rdata;
  assign sfr_rdata_o     = sfr_rdata;
  assign sfr_rvalid_o    = sfr_rvalid;
  assign timer_count_o   = timer;
  assign overflow_flag_o = flag;
  assign wdt_timeout_o   = wdt_to;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wrap;
    (timer == TPS_TMR_MAX) ##0 timer_inc;
  endsequence

  sequence s_wdt_ratio1;
    mode.prescale_to_watchdog && !wdt_int_mode_i &&
    (mode.prescale_ratio_select == 3'h0) ##0 wdt_tick_i;
  endsequence

  a_timer_hold: assert property ( // R12
    !run_enable_i |=> (timer == $past(timer)))
    else $error("timer moved while disabled");

  a_wrap_flag: assert property ( // R14 R13
    s_wrap |=> (timer == TPS_TMR_RESET) && flag)
    else $error("wrap did not clear timer and set flag");

  a_flag_set_wins: assert property ( // R13
    flag_set && flag_clr_i |=> flag ##1 (flag || $past(flag_clr_i)))
    else $error("overflow lost against clear");

  a_wdt_bypass: assert property ( // R15
    mode.prescale_to_watchdog && src_evt && run_enable_i
      |=> timer == $past(timer) + TPS_ONE8)
    else $error("timer divided while prescaler on watchdog");

  a_t0_div256: assert property ( // R1
    !mode.prescale_to_watchdog && (mode.prescale_ratio_select == 3'h7)
      && timer_inc |=> psc_cnt == TPS_ZERO8)
    else $error("divide by 256 ticked off wrap");

  a_wdt_div1: assert property ( // R2
    s_wdt_ratio1 |=> wdt_timeout_o)
    else $error("watchdog ratio one missed a tick");

  a_wdt_int_div2: assert property ( // R3
    mode.prescale_to_watchdog && wdt_int_mode_i &&
    (mode.prescale_ratio_select == 3'h0) && wdt_tick_i && !psc_cnt[0]
      |=> !wdt_timeout_o)
    else $error("watchdog interrupt ratio passed odd tick");

  a_edge_fall: assert property ( // R6 R7
    mode.count_source_select && mode.count_edge_select &&
    (src_level && !src_prev) |-> !src_evt)
    else $error("rising edge counted with falling selected");

  a_pscv_read: assert property ( // R11
    sfr_rd_i && (sfr_addr_i == TPS_PSCV_ADDR)
      |=> sfr_rvalid_o && (sfr_rdata_o == $past(psc_cnt)))
    else $error("count view read wrong value");

  a_mode_read: assert property ( // R10 R9
    mode_wr_i ##1 mode_rd_i |=> mode_rdata_o == $past(mode_wdata_i, 2))
    else $error("mode register did not read back");

endmodule

/* File: include/tps_pkg.sv */
// timer0 prescaler and clock select constants and types
package tps_pkg;

  localparam logic [7:0] TPS_PSCV_ADDR  = 8'h0A;
  localparam logic [7:0] TPS_MODE_RESET = 8'h3F;
  localparam logic [7:0] TPS_PSC_RESET  = 8'hFF;
  localparam logic [7:0] TPS_TMR_RESET  = 8'h00;
  localparam logic [7:0] TPS_TMR_MAX    = 8'hFF;
  localparam logic [7:0] TPS_ZERO8      = 8'h00;
  localparam logic [7:0] TPS_ONE8       = 8'h01;
  localparam logic [3:0] TPS_EXP_ONE    = 4'h1;
  localparam int         TPS_PSC_BITS   = 8;

  typedef struct packed {
    logic       low_osc_source_select;
    logic       spare_storage_bit;
    logic       count_source_select;
    logic       count_edge_select;
    logic       prescale_to_watchdog;
    logic [2:0] prescale_ratio_select;
  } tps_mode_t;

  typedef enum logic [1:0] {
    TPS_SRC_INSTR = 2'b00,
    TPS_SRC_PIN   = 2'b01,
    TPS_SRC_LOSC  = 2'b10
  } tps_src_t;

endpackage

/* File: sim/tps_timer0_tb_top.sv */
// self-checking bench for the timer0 prescaler and clock select block
module tps_timer0_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tps_pkg::*;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       mwr = 1'b0, mrd = 1'b0, srd = 1'b0, pin = 1'b0, lo = 1'b0;
  logic       en = 1'b0, wim = 1'b0, wtk = 1'b0, clr = 1'b0;
  logic [7:0] mwd = 8'h00, sadr = 8'h00, mrdat, srdat, tmr;
  logic       srv, flg, wto;
  int         n_errors = 0, num_checks = 0, n_to = 0, cyc = 0, base;

  tps_timer0 u_tps_timer0 (
    .core_clk_i(clk), .reset_i(rst), .mode_wr_i(mwr), .mode_wdata_i(mwd),
    .mode_rd_i(mrd), .mode_rdata_o(mrdat), .sfr_rd_i(srd),
    .sfr_addr_i(sadr), .sfr_rdata_o(srdat), .sfr_rvalid_o(srv),
    .ext_clk_pin_i(pin), .low_osc_i(lo), .run_enable_i(en),
    .wdt_int_mode_i(wim), .wdt_tick_i(wtk), .flag_clr_i(clr),
    .timer_count_o(tmr), .overflow_flag_o(flg), .wdt_timeout_o(wto));

  initial forever #25 clk = ~clk;

  // counts watchdog timeouts and cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wto === 1'b1) n_to <= n_to + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    go(7);
    rst <= 1'b0;
  endtask

  task automatic mw(input logic [7:0] d);
    @(posedge clk);
    mwr <= 1'b1;
    mwd <= d;
    @(posedge clk);
    mwr <= 1'b0;
  endtask

  task automatic mr(input logic [7:0] exp);
    @(posedge clk);
    mrd <= 1'b1;
    @(posedge clk);
    mrd <= 1'b0;
    #1 chk(mrdat, exp, "mode read");
  endtask

  // mode write with the read instruction on the very next edge
  task automatic mwr_rd(input logic [7:0] d);
    @(posedge clk);
    mwr <= 1'b1;
    mwd <= d;
    @(posedge clk);
    mwr <= 1'b0;
    mrd <= 1'b1;
    @(posedge clk);
    mrd <= 1'b0;
    #1 chk(mrdat, d, "mode back to back");
  endtask

  task automatic sr(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    srd <= 1'b1;
    sadr <= a;
    @(posedge clk);
    srd <= 1'b0;
    #1 chk({7'h00, srv}, 8'h01, "read valid");
    chk(srdat, exp, "read data");
    @(posedge clk);
    #1 chk({7'h00, srv}, 8'h00, "valid drop");
  endtask

  // e enabled timer events, or e watchdog ticks when w is set
  task automatic run(input int e, input bit w);
    @(posedge clk);
    wtk <= w;
    en <= !w;
    repeat (e) @(posedge clk);
    wtk <= 1'b0;
    en <= 1'b0;
    go(3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_rst();
    mr(TPS_MODE_RESET);
    sr(TPS_PSCV_ADDR, TPS_PSC_RESET);
    sr(8'h0B, 8'h00);
    mw(8'h5A);
    mr(8'h5A);
    mwr_rd(8'hA5);
    for (int s = 0; s < 8; s++) begin
      do_rst();
      mw(8'(s));
      run((4 << s) + 1, 1'b0);
      chk(tmr, 8'h03, "timer ratio");
      go(4);
      chk(tmr, 8'h03, "timer hold");
      sr(TPS_PSCV_ADDR, 8'(4 << s));
    end
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        do_rst();
        wim <= m[0];
        mw(8'h08 | 8'(s));
        base = n_to;
        run((2 << (s + m)) + 1, 1'b1);
        chk(8'(n_to - base), 8'h03, "watchdog ratio");
      end
    end
    for (int k = 0; k < 4; k++) begin
      do_rst();
      mw({k[1], 2'h1, k[0], 4'h8});
      en <= 1'b1;
      for (int i = 0; i < 5; i++) begin
        @(posedge clk);
        pin <= k[1] | (i < 3);
        lo <= !k[1] | (i < 3);
        go(2);
        pin <= 1'b0;
        lo <= 1'b0;
        go(2);
      end
      {lo, pin} <= k[1] ? 2'h2 : 2'h1;
      go(3);
      chk(tmr, 8'(4 - k[0]), "edge count");
      en <= 1'b0;
      {lo, pin} <= 2'h0;
    end
    do_rst();
    mw(8'h08);
    run(255, 1'b0);
    chk(tmr, TPS_TMR_MAX, "undivided count");
    chk({7'h00, flg}, 8'h00, "early flag");
    run(1, 1'b0);
    chk(tmr, TPS_TMR_RESET, "wrap");
    go(4);
    chk({7'h00, flg}, 8'h01, "flag set");
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    go(2);
    chk({7'h00, flg}, 8'h00, "flag clear");
    run(255, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    clr <= 1'b0;
    go(2);
    chk(tmr, TPS_TMR_RESET, "second wrap");
    chk({7'h00, flg}, 8'h01, "set beats clear");
    results();
  end
endmodule
